// >>> rtl/ppm_mux.sv
// two 8-bit ports with per-pin peripheral function mux and wishbone regs
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"

// Overview of operation
// (RULE1) p1.0 peripheral: drive low, pin to timer clock
// (RULE2) p1.1-3: compare outs 0-2, capture a inputs
// (RULE3) p1.4 peripheral: sub-main clock out, input unused
// (RULE4) p1.5-7: compare outs 0-2, inputs unused
// (RULE5) direction always from direction bit; p2.6-7 output enables are held low instead, whatever dir says
// (RULE6) p2.0 peripheral: auxiliary clock out
// (RULE7) p2.1: drive low, pin to alternate clock
// (RULE8) p2.2-3: compare outs 0-1, capture b inputs
// (RULE9) p2.4: compare out 2, input unused
// (RULE10) p2.6-7 unbonded: output low, no input
// (RULE11) p2.6-7 flags change by software only
// (RULE12) p2.5 also carries oscillator resistor pin
// (RULE13) plain mode: output register drives, pin readable
// (RULE14) chosen edge sets flag; flag and enable interrupt
module ppm_mux (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // port 1 pins
    input wire logic [7:0] p1_pin_i,
    output logic [7:0] p1_pin_o,
    output logic [7:0] p1_pin_oe_o,
    // port 2 pins, bits 6 and 7 have no pad
    input wire logic [7:0] p2_pin_i,
    output logic [7:0] p2_pin_o,
    output logic [7:0] p2_pin_oe_o,
    // timer and clock module signals
    input wire logic timer_compare_out_0_i,
    input wire logic timer_compare_out_1_i,
    input wire logic timer_compare_out_2_i,
    input wire logic sub_main_clock_i,
    input wire logic aux_clock_i,
    output logic timer_external_clock_in_o,
    output logic timer_alt_clock_in_o,
    output logic capture_in_ch0_a_o,
    output logic capture_in_ch1_a_o,
    output logic capture_in_ch2_a_o,
    output logic capture_in_ch0_b_o,
    output logic capture_in_ch1_b_o,
    output logic oscillator_resistor_en_o,
    // interrupt requests per port
    output logic p1_irq_o,
    output logic p2_irq_o
);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    ppm_pkg::ppm_cfg_type p1_cfg_q;
    ppm_pkg::ppm_cfg_type p1_cfg_d;
    ppm_pkg::ppm_cfg_type p2_cfg_q;
    ppm_pkg::ppm_cfg_type p2_cfg_d;
    ppm_pkg::ppm_bus_state_type bus_q;
    ppm_pkg::ppm_bus_state_type bus_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] p1_in;
    logic [7:0] p2_in;
    logic [7:0] p1_flag;
    logic [7:0] p2_flag;
    logic [7:0] p1_mod_out;
    logic [7:0] p2_mod_out;
    logic [7:0] wbyte;
    logic req;
    logic wr_go;
    logic p1_flag_we;
    logic p2_flag_we;

    assign req = wb_cyc_i & wb_stb_i;
    assign wbyte = wb_dat_i[7:0];
    // only the low lane holds data; writes need sel[0]
    // a write lands at the taking edge; the idle gate stops a request
    // that is still held during its ack cycle from writing twice
    assign wr_go = req & wb_we_i & wb_sel_i[0]
        & (bus_q == ppm_pkg::PPM_IDLE);
    assign p1_flag_we = wr_go & (wb_adr_i == `PPM_OFS_P1_IFG);
    assign p2_flag_we = wr_go & (wb_adr_i == `PPM_OFS_P2_IFG);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // pads are asynchronous: two flops, so every pin reaches the
    // registers and the timer two cycles late
    ppm_sync u_sync_p1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(p1_pin_i),
        .q_o(p1_in)
    );

    ppm_sync u_sync_p2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(p2_pin_i),
        .q_o(p2_in)
    );

    // ------------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------------
    // every port 1 bit has a pad, so all eight edges count
    ppm_port_irq u_irq_p1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(p1_in),
        .pin_edge_select_i(p1_cfg_q.ies),
        .pin_irq_enable_i(p1_cfg_q.ie),
        .edge_mask_i(8'hFF),
        .flag_we_i(p1_flag_we),
        .flag_wdata_i(wbyte),
        .pin_irq_flag_o(p1_flag),
        .irq_o(p1_irq_o)
    );

    // unbonded bits get no edges: software alone moves their flags
    ppm_port_irq u_irq_p2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(p2_in),
        .pin_edge_select_i(p2_cfg_q.ies),
        .pin_irq_enable_i(p2_cfg_q.ie),
        .edge_mask_i(~`PPM_P2_UNBONDED), // RULE11
        .flag_we_i(p2_flag_we),
        .flag_wdata_i(wbyte),
        .pin_irq_flag_o(p2_flag),
        .irq_o(p2_irq_o)
    );

    // ------------------------------------------------------------------
    // module outputs per bit
    // ------------------------------------------------------------------
    always_comb begin
        p1_mod_out = {
            timer_compare_out_2_i, // RULE4
            timer_compare_out_1_i,
            timer_compare_out_0_i,
            sub_main_clock_i, // RULE3
            timer_compare_out_2_i, // RULE2
            timer_compare_out_1_i,
            timer_compare_out_0_i,
            1'b0 // RULE1
        };
        // the sources share this clock, so they pass straight to the pads
        p2_mod_out = {
            1'b0, // RULE10
            1'b0,
            // p2.5 has no module output, only the resistor hookup
            1'b0,
            timer_compare_out_2_i, // RULE9
            timer_compare_out_1_i, // RULE8
            timer_compare_out_0_i,
            1'b0, // RULE7
            aux_clock_i // RULE6
        };
    end

    // ------------------------------------------------------------------
    // pad drive: select picks source, direction bit alone sets enable, except on p2.6-7
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pad
            assign p1_pin_o[g] = p1_cfg_q.sel[g] ? p1_mod_out[g]
                : p1_cfg_q.out[g]; // RULE13
            assign p1_pin_oe_o[g] = p1_cfg_q.dir[g]; // RULE5
            // no pad behind bits 6 and 7: never enabled, whatever dir says
            if (g >= 6) begin : g_nopad
                assign p2_pin_o[g] = 1'b0; // RULE10
                assign p2_pin_oe_o[g] = 1'b0; // RULE10
            end else begin : g_pad2
                assign p2_pin_o[g] = p2_cfg_q.sel[g] ? p2_mod_out[g]
                    : p2_cfg_q.out[g]; // RULE13
                assign p2_pin_oe_o[g] = p2_cfg_q.dir[g]; // RULE5
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // pin inputs to the timer, gated by the function select
    // ------------------------------------------------------------------
    // gating by select keeps plain port traffic away from the timer
    assign timer_external_clock_in_o = p1_cfg_q.sel[0] & p1_in[0]; // RULE1
    assign capture_in_ch0_a_o = p1_cfg_q.sel[1] & p1_in[1]; // RULE2
    assign capture_in_ch1_a_o = p1_cfg_q.sel[2] & p1_in[2]; // RULE2
    assign capture_in_ch2_a_o = p1_cfg_q.sel[3] & p1_in[3]; // RULE2
    assign timer_alt_clock_in_o = p2_cfg_q.sel[1] & p2_in[1]; // RULE7
    assign capture_in_ch0_b_o = p2_cfg_q.sel[2] & p2_in[2]; // RULE8
    assign capture_in_ch1_b_o = p2_cfg_q.sel[3] & p2_in[3]; // RULE8
    // resistor hookup is analogue; this level tells the clock module
    assign oscillator_resistor_en_o = p2_cfg_q.sel[`PPM_OSCILLATOR_RESISTOR_PIN_BIT]; // RULE12

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // no IN or IFG here: IN is read-only, and IFG lives in the edge
    // logic so that a hardware set can win over a software clear
    always_comb begin
        p1_cfg_d = p1_cfg_q;
        p2_cfg_d = p2_cfg_q;
        if (wr_go) begin
            case (wb_adr_i)
                `PPM_OFS_P1_OUT: p1_cfg_d.out = wbyte;
                `PPM_OFS_P1_DIR: p1_cfg_d.dir = wbyte;
                `PPM_OFS_P1_IES: p1_cfg_d.ies = wbyte;
                `PPM_OFS_P1_IE: p1_cfg_d.ie = wbyte;
                `PPM_OFS_P1_SEL: p1_cfg_d.sel = wbyte;
                `PPM_OFS_P2_OUT: p2_cfg_d.out = wbyte;
                `PPM_OFS_P2_DIR: p2_cfg_d.dir = wbyte;
                `PPM_OFS_P2_IES: p2_cfg_d.ies = wbyte;
                `PPM_OFS_P2_IE: p2_cfg_d.ie = wbyte;
                `PPM_OFS_P2_SEL: p2_cfg_d.sel = wbyte;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // ports come up as plain inputs: no drive, no select
            p1_cfg_q <= '{`PPM_RST_BYTE, `PPM_RST_BYTE, `PPM_RST_BYTE,
                `PPM_RST_BYTE, `PPM_RST_BYTE};
            p2_cfg_q <= '{`PPM_RST_BYTE, `PPM_RST_BYTE, `PPM_RST_BYTE,
                `PPM_RST_BYTE, `PPM_RST_BYTE};
        end else begin
            p1_cfg_q <= p1_cfg_d;
            p2_cfg_q <= p2_cfg_d;
        end
    end

    // ------------------------------------------------------------------
    // bus answer: ack one cycle after request, read data registered
    // ------------------------------------------------------------------
    always_comb begin
        bus_d = bus_q;
        rdata_d = rdata_q;
        case (bus_q)
            ppm_pkg::PPM_IDLE: begin
                if (req) begin
                    bus_d = ppm_pkg::PPM_ACK;
                    rdata_d = 32'h0000_0000;
                    case (wb_adr_i)
                        `PPM_OFS_P1_IN: rdata_d[7:0] = p1_in; // RULE13
                        `PPM_OFS_P1_OUT: rdata_d[7:0] = p1_cfg_q.out;
                        `PPM_OFS_P1_DIR: rdata_d[7:0] = p1_cfg_q.dir;
                        `PPM_OFS_P1_IFG: rdata_d[7:0] = p1_flag;
                        `PPM_OFS_P1_IES: rdata_d[7:0] = p1_cfg_q.ies;
                        `PPM_OFS_P1_IE: rdata_d[7:0] = p1_cfg_q.ie;
                        `PPM_OFS_P1_SEL: rdata_d[7:0] = p1_cfg_q.sel;
                        `PPM_OFS_P2_IN: rdata_d[7:0] = p2_in
                            & ~`PPM_P2_UNBONDED; // RULE10
                        `PPM_OFS_P2_OUT: rdata_d[7:0] = p2_cfg_q.out;
                        `PPM_OFS_P2_DIR: rdata_d[7:0] = p2_cfg_q.dir;
                        `PPM_OFS_P2_IFG: rdata_d[7:0] = p2_flag;
                        `PPM_OFS_P2_IES: rdata_d[7:0] = p2_cfg_q.ies;
                        `PPM_OFS_P2_IE: rdata_d[7:0] = p2_cfg_q.ie;
                        `PPM_OFS_P2_SEL: rdata_d[7:0] = p2_cfg_q.sel;
                        // unmapped offsets read zero, still acked
                        default: rdata_d = 32'h0000_0000;
                    endcase
                end
            end
            ppm_pkg::PPM_ACK: begin
                // back to idle even if the master still holds its request
                bus_d = ppm_pkg::PPM_IDLE;
            end
            default: begin
                bus_d = ppm_pkg::PPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= ppm_pkg::PPM_IDLE;
            rdata_q <= 32'h0000_0000;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    assign wb_ack_o = (bus_q == ppm_pkg::PPM_ACK) & req;
    // read data stands in a register from ack until the next request
    assign wb_dat_o = rdata_q;

endmodule : ppm_mux

`default_nettype wire

// >>> rtl/ppm_params.svh
// offsets, field positions and reset values of the port function mux
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// ----------------------------------------------------------------------
// register word offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define PPM_OFS_P1_IN 8'h00
`define PPM_OFS_P1_OUT 8'h04
`define PPM_OFS_P1_DIR 8'h08
`define PPM_OFS_P1_IFG 8'h0C
`define PPM_OFS_P1_IES 8'h10
`define PPM_OFS_P1_IE 8'h14
`define PPM_OFS_P1_SEL 8'h18
`define PPM_OFS_P2_IN 8'h20
`define PPM_OFS_P2_OUT 8'h24
`define PPM_OFS_P2_DIR 8'h28
`define PPM_OFS_P2_IFG 8'h2C
`define PPM_OFS_P2_IES 8'h30
`define PPM_OFS_P2_IE 8'h34
`define PPM_OFS_P2_SEL 8'h38

// ----------------------------------------------------------------------
// reset values and bit groups
// ----------------------------------------------------------------------
`define PPM_RST_BYTE 8'h00
`define PPM_P2_UNBONDED 8'hC0
`define PPM_OSCILLATOR_RESISTOR_PIN_BIT 5

`endif

// >>> rtl/ppm_pkg.sv
// types shared by the port function mux files
package ppm_pkg;

    // ------------------------------------------------------------------
    // per-port configuration bundle
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] dir;
        logic [7:0] out;
        logic [7:0] ie;
        logic [7:0] ies;
    } ppm_cfg_type;

    // ------------------------------------------------------------------
    // bus slave states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PPM_IDLE = 2'b01,
        PPM_ACK = 2'b10
    } ppm_bus_state_type;

endpackage : ppm_pkg

// >>> rtl/ppm_port_irq.sv
// edge detection and sticky flags of one 8-bit port
`timescale 1ns/1ps
`default_nettype none

module ppm_port_irq (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // synchronised pin levels and settings
    input wire logic [7:0] pin_i,
    input wire logic [7:0] pin_edge_select_i,
    input wire logic [7:0] pin_irq_enable_i,
    input wire logic [7:0] edge_mask_i,
    // software write of the flag byte
    input wire logic flag_we_i,
    input wire logic [7:0] flag_wdata_i,
    // flags and request
    output logic [7:0] pin_irq_flag_o,
    output logic irq_o
);

    logic [7:0] prev_q;
    logic [7:0] prev_d;
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [7:0] hit;

    // ------------------------------------------------------------------
    // per-bit edge select and flag
    // ------------------------------------------------------------------
    always_comb begin
        prev_d = pin_i;
        hit = 8'h00;
        flag_d = flag_q;
        if (flag_we_i) begin
            flag_d = flag_wdata_i;
        end
        // edge set wins over a same-cycle software clear
        for (int b = 0; b < 8; b++) begin
            hit[b] = edge_mask_i[b] & (pin_edge_select_i[b] ?
                (prev_q[b] & ~pin_i[b]) : (~prev_q[b] & pin_i[b])); // RULE14
            if (hit[b]) begin
                flag_d[b] = 1'b1; // RULE14
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 8'h00;
            flag_q <= 8'h00;
        end else begin
            prev_q <= prev_d;
            flag_q <= flag_d;
        end
    end

    assign pin_irq_flag_o = flag_q;
    assign irq_o = |(flag_q & pin_irq_enable_i); // RULE14

endmodule : ppm_port_irq

`default_nettype wire

// >>> rtl/ppm_sync.sv
// two-stage synchroniser for one byte of pin levels
`timescale 1ns/1ps
`default_nettype none

module ppm_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // async byte in, synced byte out
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);

    logic [7:0] meta_q;
    logic [7:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule : ppm_sync

`default_nettype wire

// >>> test/ppm_far_model.sv
// timer and clock module sources facing the port function mux
`timescale 1ns/1ps
`default_nettype none

module ppm_far_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // compare outputs and clocks
    output logic [2:0] compare_o,
    output logic sub_main_clock_o,
    output logic aux_clock_o
);
    logic [4:0] cnt_q;

    // unlike rates, so a wrong route shows up as a wrong level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    assign sub_main_clock_o = cnt_q[0];
    assign aux_clock_o = cnt_q[2];
    assign compare_o = {cnt_q[4] ^ cnt_q[0], cnt_q[3], cnt_q[1] ^ cnt_q[2]};
endmodule : ppm_far_model

`default_nettype wire

// >>> test/ppm_mux_assertions.sv
// concurrent checks on the ports of the port function mux
`timescale 1ns/1ps
`default_nettype none

module ppm_mux_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and timer side
    input wire logic [7:0] p1_pin_i,
    input wire logic [7:0] p2_pin_i,
    input wire logic [7:0] p1_pin_oe_o,
    input wire logic [7:0] p2_pin_o,
    input wire logic [7:0] p2_pin_oe_o,
    input wire logic timer_external_clock_in_o,
    input wire logic timer_alt_clock_in_o,
    input wire logic capture_in_ch0_a_o,
    input wire logic capture_in_ch0_b_o,
    input wire logic oscillator_resistor_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----
    // bus steps
    // ----
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // settings only move on an acknowledged write
    sequence s_wr_ack;
        $rose(wb_ack_o) && wb_we_i;
    endsequence

    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_REQ: assert property (wb_ack_o |->
        wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    // synchroniser delay of two edges before a pin reaches the timer
    AST_EXT_CLK: assert property (
        timer_external_clock_in_o |-> $past(p1_pin_i[0], 2))
        else $error("timer clock input without pin level");
    AST_CAP_A: assert property (
        capture_in_ch0_a_o |-> $past(p1_pin_i[1], 2))
        else $error("capture a input without pin level");
    AST_ALT_CLK: assert property (
        timer_alt_clock_in_o |-> $past(p2_pin_i[1], 2))
        else $error("alternate clock input without pin level");
    AST_CAP_B: assert property (
        capture_in_ch0_b_o |-> $past(p2_pin_i[2], 2))
        else $error("capture b input without pin level");
    AST_UNBONDED: assert property (
        p2_pin_o[7:6] == 2'b00 && p2_pin_oe_o[7:6] == 2'b00)
        else $error("unbonded bits driven");
    AST_DIR_P1: assert property ($changed(p1_pin_oe_o) |-> s_wr_ack)
        else $error("port 1 enable moved without write");
    AST_DIR_P2: assert property ($changed(p2_pin_oe_o) |-> s_wr_ack)
        else $error("port 2 enable moved without write");
    AST_OSCILLATOR_RESISTOR_PIN: assert property (
        $changed(oscillator_resistor_en_o) |-> s_wr_ack)
        else $error("resistor enable moved without write");
endmodule : ppm_mux_assertions

bind ppm_mux ppm_mux_assertions i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i),
    .p1_pin_oe_o(p1_pin_oe_o), .p2_pin_o(p2_pin_o),
    .p2_pin_oe_o(p2_pin_oe_o),
    .timer_external_clock_in_o(timer_external_clock_in_o),
    .timer_alt_clock_in_o(timer_alt_clock_in_o),
    .capture_in_ch0_a_o(capture_in_ch0_a_o),
    .capture_in_ch0_b_o(capture_in_ch0_b_o),
    .oscillator_resistor_en_o(oscillator_resistor_en_o));

`default_nettype wire

// >>> test/tb_port_pin_function_mux.sv
// self-checking bench for the port function mux
`timescale 1ns/1ps
`default_nettype none

module tb_port_pin_function_mux;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o;
    logic [7:0] p1_pin_i = 8'h00;
    logic [7:0] p2_pin_i = 8'h00;
    logic [7:0] p1_pin_o, p1_pin_oe_o, p2_pin_o, p2_pin_oe_o;
    logic [2:0] tco;
    logic sub_main_clock_i, aux_clock_i, p1_irq_o, p2_irq_o;
    logic timer_external_clock_in_o, timer_alt_clock_in_o;
    logic capture_in_ch0_a_o, capture_in_ch1_a_o, capture_in_ch2_a_o;
    logic capture_in_ch0_b_o, capture_in_ch1_b_o, oscillator_resistor_en_o;
    logic [7:0] rg[16];
    int fails = 0;
    int compares = 0;
    int seed = 32'h5AC7;

    always #4 clk_i = ~clk_i;

    ppm_mux i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o),
        .p1_pin_oe_o(p1_pin_oe_o), .p2_pin_i(p2_pin_i),
        .p2_pin_o(p2_pin_o), .p2_pin_oe_o(p2_pin_oe_o),
        .timer_compare_out_0_i(tco[0]), .timer_compare_out_1_i(tco[1]),
        .timer_compare_out_2_i(tco[2]),
        .sub_main_clock_i(sub_main_clock_i), .aux_clock_i(aux_clock_i),
        .timer_external_clock_in_o(timer_external_clock_in_o),
        .timer_alt_clock_in_o(timer_alt_clock_in_o),
        .capture_in_ch0_a_o(capture_in_ch0_a_o),
        .capture_in_ch1_a_o(capture_in_ch1_a_o),
        .capture_in_ch2_a_o(capture_in_ch2_a_o),
        .capture_in_ch0_b_o(capture_in_ch0_b_o),
        .capture_in_ch1_b_o(capture_in_ch1_b_o),
        .oscillator_resistor_en_o(oscillator_resistor_en_o),
        .p1_irq_o(p1_irq_o), .p2_irq_o(p2_irq_o));
    ppm_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .compare_o(tco),
        .sub_main_clock_o(sub_main_clock_i), .aux_clock_o(aux_clock_i));

    // ----
    // tasks
    // ----
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= s;
        // only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // input, gap and unmapped words keep their model value
        if (w && s[0] && a < 8'h40 && a[4:2] != 3'h0 && a[4:2] != 3'h7)
            rg[a[5:2]] = d[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        bus(a, 1'b1, d, s);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        e = 32'h00000000;
        if (a < 8'h40 && a[4:2] != 3'h7) e[7:0] = rg[a[5:2]];
        bus(a, 1'b0, 32'h00000000, 4'hF);
        chk("read", e, q);
    endtask : rd

    task automatic pins(input logic [7:0] n1, input logic [7:0] n2);
        logic [7:0] o1, o2, m1, m2, mk;
        o1 = rg[0];
        o2 = rg[8];
        @(posedge clk_i);
        p1_pin_i <= n1;
        p2_pin_i <= n2;
        rg[0] = n1;
        rg[8] = n2 & 8'h3F;
        rg[3] |= ~rg[4] & ~o1 & n1 | rg[4] & o1 & ~n1;
        rg[11] |= (~rg[12] & ~o2 & rg[8] | rg[12] & o2 & ~rg[8]) & 8'h3F;
        repeat (4) @(posedge clk_i);
        #1;
        m1 = {tco, sub_main_clock_i, tco, 1'b0};
        m2 = {3'b000, tco, 1'b0, aux_clock_i};
        // p2.5 output in peripheral mode is left open
        mk = rg[14][5] ? 8'hDF : 8'hFF;
        m1 = m1 & rg[6] | rg[1] & ~rg[6];
        m2 = (m2 & rg[14] | rg[9] & ~rg[14]) & 8'h3F & mk;
        chk("p1 out", m1, p1_pin_o);
        chk("p2 out", m2, p2_pin_o & mk);
        chk("dir 1", rg[2], p1_pin_oe_o);
        chk("dir 2", rg[10] & 8'h3F, p2_pin_oe_o);
        chk("timer in", {rg[6][3:0] & rg[0][3:0], rg[14][3:1] & rg[8][3:1]},
            {capture_in_ch2_a_o, capture_in_ch1_a_o, capture_in_ch0_a_o,
             timer_external_clock_in_o, capture_in_ch1_b_o,
             capture_in_ch0_b_o, timer_alt_clock_in_o});
        chk("oscillator_resistor_pin", rg[14][5], oscillator_resistor_en_o);
        chk("irq 1", |(rg[3] & rg[5]), p1_irq_o);
        chk("irq 2", |(rg[11] & rg[13]), p2_irq_o);
    endtask : pins

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // ----
    // sequence
    // ----
    initial begin
        for (int i = 0; i < 16; i++) rg[i] = 8'h00;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 64; a += 4) rd(8'(a));
        wr(8'h34, 32'h000000C0);
        // pad edges on the unbonded bits must leave their flags clear
        pins(8'hFF, 8'hC0);
        wr(8'h30, 32'h000000C0);
        wr(8'h2C, 32'h000000C0);
        pins(8'h00, 8'h00);
        rd(8'h2C);
        wr(8'h2C, 32'h00000000);
        for (int i = 0; i < 100; i++) begin
            wr(8'($random(seed)) & 8'h7C, $random(seed), 4'($random(seed)));
            pins(8'($random(seed)), 8'($random(seed)));
            rd(8'($random(seed)) & 8'h7C);
            rd(8'h0C);
            rd(8'h2C);
        end
        end_of_test();
    end

    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : tb_port_pin_function_mux

`default_nettype wire
